/* File: hdl/rxts_pkg.sv */
package rxts_pkg;
  // widths
  localparam int TS_W = 32;
  localparam int DATA_W = 8;
  localparam int ETYPE_W = 16;
  // values after reset, then fifo depths
  localparam logic [TS_W-1:0] TIME_RST = 32'h0000_0000;
  localparam logic [ETYPE_W-1:0] ETYPE_RST = 16'h0000;
  localparam int FIFO_DEPTH = 4;
  localparam int EVT_DEPTH = 4;

  // one received byte with frame markers
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic sof;
    logic eof;
  } rxts_beat_t;

  // packet states of the host-side path
  typedef enum logic [1:0] {
    RXTS_IDLE = 2'b00,
    RXTS_WAIT_TS = 2'b01,
    RXTS_PASS = 2'b10
  } rxts_state_t;
endpackage

/* File: hdl/rxts_fifo.sv */
`timescale 1ns/1ps
// small flop fifo with valid/ready on both sides
module rxts_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = rxts_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } rxts_fifo_st_t;
  rxts_fifo_st_t s_r, s_nxt;
  logic push, pop;

  assign in_ready = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count update; count guards full/empty honestly
  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(DEPTH-1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop)
      s_nxt.rp = (s_r.rp == AW'(DEPTH-1)) ? '0 : s_r.rp + 1'b1;
    if (push && !pop)
      s_nxt.cnt = s_r.cnt + 1'b1;
    else if (pop && !push)
      s_nxt.cnt = s_r.cnt - 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
endmodule

/* File: hdl/rxts_top.sv */
`timescale 1ns/1ps
// Overview of operation
// R1 - two timestamp paths: event fifo, per-packet
// R2 - record event on matching ethertype frame
// R3 - host reads event fifo separately from payload
// R4 - host mode timestamps every packet with payload
// R5 - in host mode each port fifo packet waits for timestamp
// R6 - lost request on bad preamble locks fifo
// R7 - clearing host enable stops requests, no lockup
// R8 - host keeps per-packet timestamping disabled
module rxts_top (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // configuration levels
  input wire logic HOST_TS_EN,
  input wire logic [rxts_pkg::ETYPE_W-1:0] EVT_ETYPE,
  // receive mac stream, same clock domain
  input wire logic RX_VALID,
  input wire logic [rxts_pkg::DATA_W-1:0] RX_DATA,
  input wire logic RX_SOF,
  input wire logic RX_EOF,
  input wire logic RX_PREAMBLE_OK,
  output logic RX_READY,
  // host dma stream
  output logic DMA_VALID,
  input wire logic DMA_READY,
  output logic [rxts_pkg::DATA_W-1:0] DMA_DATA,
  output logic DMA_SOF,
  output logic DMA_EOF,
  output logic DMA_TS_VALID,
  output logic [rxts_pkg::TS_W-1:0] DMA_TS,
  // event fifo read port
  input wire logic EVT_POP,
  output logic EVT_VALID,
  output logic [rxts_pkg::TS_W-1:0] EVT_TS,
  // status
  output logic PORT_STALLED
);
  localparam int EAW = $clog2(rxts_pkg::EVT_DEPTH);
  localparam int PAW = $clog2(rxts_pkg::FIFO_DEPTH);

  typedef struct packed {
    logic [rxts_pkg::TS_W-1:0] time_now;
    rxts_pkg::rxts_state_t state;
    logic ts_req;
    logic ts_have;
    logic [rxts_pkg::TS_W-1:0] ts_held;
    logic [rxts_pkg::TS_W-1:0] sof_time;
    logic [1:0] byte_idx;
    logic [rxts_pkg::ETYPE_W-1:0] etype;
    logic etype_done;
    logic [rxts_pkg::EVT_DEPTH-1:0][rxts_pkg::TS_W-1:0] evt_mem;
    logic [EAW-1:0] evt_wp;
    logic [EAW-1:0] evt_rp;
    logic [EAW:0] evt_cnt;
    logic dma_valid;
    logic [rxts_pkg::DATA_W-1:0] dma_data;
    logic dma_sof;
    logic dma_eof;
    logic dma_ts_valid;
    logic [rxts_pkg::TS_W-1:0] dma_ts;
    logic evt_valid;
    logic [rxts_pkg::TS_W-1:0] evt_ts;
    logic stalled;
    logic rx_ready;
    logic [PAW:0] fill;
  } rxts_st_t;

  rxts_st_t s_r, s_nxt;
  rxts_pkg::rxts_beat_t f_in, f_out;
  logic f_in_ready, f_out_valid, f_out_ready;
  logic rx_take, evt_push, evt_pop;

  function automatic logic [EAW-1:0] ptr_inc(input logic [EAW-1:0] p);
    ptr_inc = (p == EAW'(rxts_pkg::EVT_DEPTH-1)) ? '0 : p + 1'b1;
  endfunction

  // a beat counts only while the registered ready is shown to the mac
  assign rx_take = RX_VALID && s_r.rx_ready && f_in_ready;
  assign f_in = '{data: RX_DATA, sof: RX_SOF, eof: RX_EOF};

  // port fifo sits in the data path; its ready throttles the mac
  rxts_fifo #(.WIDTH($bits(rxts_pkg::rxts_beat_t)), .DEPTH(rxts_pkg::FIFO_DEPTH)) u_port_fifo (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .in_valid(RX_VALID && s_r.rx_ready),
    .in_ready(f_in_ready),
    .in_data(f_in),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out)
  );

  // drain only when the dma register is free and the packet may proceed
  assign f_out_ready = (!s_r.dma_valid || DMA_READY) &&
                       (s_r.state == rxts_pkg::RXTS_PASS ||
                        (s_r.state == rxts_pkg::RXTS_IDLE && !(HOST_TS_EN && f_out.sof))); // [R5]

  assign evt_pop = EVT_POP && s_r.evt_valid; // [R3]

  always_comb
  begin
    s_nxt = s_r;
    evt_push = 1'b0;
    s_nxt.time_now = s_r.time_now + 1'b1;
    // mirror of the port fifo fill, so the ready pin can come from a flop
    if (rx_take && !(f_out_valid && f_out_ready))
      s_nxt.fill = s_r.fill + 1'b1;
    else if (!rx_take && f_out_valid && f_out_ready)
      s_nxt.fill = s_r.fill - 1'b1;
    s_nxt.rx_ready = (s_nxt.fill != (PAW+1)'(rxts_pkg::FIFO_DEPTH));

    // ingress side: timestamp request at sof, only with a good preamble
    s_nxt.ts_req = 1'b0;
    if (rx_take && RX_SOF)
    begin
      s_nxt.sof_time = s_r.time_now;
      s_nxt.byte_idx = '0;
      s_nxt.etype_done = 1'b0;
      s_nxt.ts_req = HOST_TS_EN && RX_PREAMBLE_OK; // [R4] [R6] [R7]
    end
    else if (rx_take && !s_r.etype_done)
    begin
      // byte count since the sof byte; the ethertype sits in the first two of them
      s_nxt.byte_idx = s_r.byte_idx + 1'b1;
      if (s_r.byte_idx == 2'd3)
        s_nxt.etype_done = 1'b1;
    end
    // simplification: ethertype taken as the first two bytes after the sof byte
    if (rx_take && !RX_SOF && !s_r.etype_done)
    begin
      if (s_r.byte_idx == 2'd0)
        s_nxt.etype[15:8] = RX_DATA;
      if (s_r.byte_idx == 2'd1)
      begin
        s_nxt.etype[7:0] = RX_DATA;
        s_nxt.etype_done = 1'b1;
        evt_push = ({s_r.etype[15:8], RX_DATA} == EVT_ETYPE); // [R2] [R1]
      end
    end
    if (s_r.ts_req)
    begin
      s_nxt.ts_have = 1'b1;
      s_nxt.ts_held = s_r.sof_time;
    end

    // event fifo storage; a full fifo drops the new event
    if (evt_push && s_r.evt_cnt != (EAW+1)'(rxts_pkg::EVT_DEPTH))
    begin
      s_nxt.evt_mem[s_r.evt_wp] = s_r.sof_time;
      s_nxt.evt_wp = ptr_inc(s_r.evt_wp);
      s_nxt.evt_cnt = s_nxt.evt_cnt + 1'b1;
    end
    if (evt_pop)
    begin
      s_nxt.evt_rp = ptr_inc(s_r.evt_rp);
      s_nxt.evt_cnt = s_nxt.evt_cnt - 1'b1;
    end
    s_nxt.evt_valid = (s_nxt.evt_cnt != '0);
    s_nxt.evt_ts = s_nxt.evt_mem[s_nxt.evt_rp];

    // host-side packet gate; no timeout, so a lost request hangs here
    case (s_r.state)
      rxts_pkg::RXTS_IDLE:
        if (f_out_valid && f_out.sof && HOST_TS_EN)
          s_nxt.state = rxts_pkg::RXTS_WAIT_TS; // [R5]
        else if (f_out_valid && f_out_ready && !f_out.eof)
          s_nxt.state = rxts_pkg::RXTS_PASS;
      rxts_pkg::RXTS_WAIT_TS:
        if (s_r.ts_have)
          s_nxt.state = rxts_pkg::RXTS_PASS;
        else if (!HOST_TS_EN)
          s_nxt.state = rxts_pkg::RXTS_PASS; // [R7]
      rxts_pkg::RXTS_PASS:
        if (f_out_valid && f_out_ready && f_out.eof)
          s_nxt.state = rxts_pkg::RXTS_IDLE;
      default:
        s_nxt.state = rxts_pkg::RXTS_IDLE;
    endcase
    s_nxt.stalled = (s_nxt.state == rxts_pkg::RXTS_WAIT_TS); // [R6]

    // dma output register; timestamp rides on the sof beat
    if (s_r.dma_valid && DMA_READY)
      s_nxt.dma_valid = 1'b0;
    if (f_out_valid && f_out_ready)
    begin
      s_nxt.dma_valid = 1'b1;
      s_nxt.dma_data = f_out.data;
      s_nxt.dma_sof = f_out.sof;
      s_nxt.dma_eof = f_out.eof;
      s_nxt.dma_ts_valid = f_out.sof && s_r.ts_have && s_r.state == rxts_pkg::RXTS_PASS; // [R4]
      s_nxt.dma_ts = s_r.ts_held;
      if (f_out.sof && s_r.state == rxts_pkg::RXTS_PASS)
        s_nxt.ts_have = s_r.ts_req;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      s_r <= '0;
      s_r.time_now <= rxts_pkg::TIME_RST;
      s_r.etype <= rxts_pkg::ETYPE_RST;
      s_r.state <= rxts_pkg::RXTS_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // every output straight from the state register
  assign RX_READY = s_r.rx_ready;
  assign DMA_VALID = s_r.dma_valid;
  assign DMA_DATA = s_r.dma_data;
  assign DMA_SOF = s_r.dma_sof;
  assign DMA_EOF = s_r.dma_eof;
  assign DMA_TS_VALID = s_r.dma_ts_valid;
  assign DMA_TS = s_r.dma_ts;
  assign EVT_VALID = s_r.evt_valid;
  assign EVT_TS = s_r.evt_ts;
  assign PORT_STALLED = s_r.stalled;
endmodule

/* File: dv/rxts_top_chk.sv */
`timescale 1ns/1ps
// port checker for the receive timestamp path
module rxts_top_chk (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // receive side
  input wire logic HOST_TS_EN,
  input wire logic RX_VALID,
  input wire logic RX_READY,
  input wire logic RX_SOF,
  input wire logic RX_PREAMBLE_OK,
  // host side
  input wire logic DMA_VALID,
  input wire logic DMA_READY,
  input wire logic [rxts_pkg::DATA_W-1:0] DMA_DATA,
  input wire logic DMA_SOF,
  input wire logic DMA_TS_VALID,
  input wire logic EVT_POP,
  input wire logic EVT_VALID,
  input wire logic [rxts_pkg::TS_W-1:0] EVT_TS,
  input wire logic PORT_STALLED
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // stamp only on a first beat, and on every first beat in host mode
  a_ts_on_sof: assert property (DMA_TS_VALID |-> DMA_VALID && DMA_SOF) else $error("stamp off first beat");
  a_ts_every: assert property (DMA_VALID && DMA_SOF && HOST_TS_EN |-> DMA_TS_VALID) else $error("no stamp");
  // a lost request must show as a stall
  a_stall_bad: assert property (RX_VALID && RX_READY && RX_SOF && !RX_PREAMBLE_OK && HOST_TS_EN
    |-> ##[1:20] PORT_STALLED) else $error("no stall");
  a_no_stall_off: assert property (!HOST_TS_EN [*4] |-> !PORT_STALLED) else $error("stall while off");
  // offered beats and event heads stand until taken
  a_dma_hold: assert property (DMA_VALID && !DMA_READY |=> DMA_VALID && $stable(DMA_DATA) && $stable(DMA_SOF))
    else $error("dma beat moved");
  a_evt_hold: assert property (EVT_VALID && !EVT_POP |=> EVT_VALID && $stable(EVT_TS)) else $error("event moved");
endmodule
bind rxts_top rxts_top_chk u_rxts_top_chk (.CORE_CLK, .RESET_N, .HOST_TS_EN, .RX_VALID, .RX_READY, .RX_SOF,
  .RX_PREAMBLE_OK, .DMA_VALID, .DMA_READY, .DMA_DATA, .DMA_SOF, .DMA_TS_VALID, .EVT_POP, .EVT_VALID, .EVT_TS,
  .PORT_STALLED);

/* File: dv/rxts_host.sv */
`timescale 1ns/1ps
// host model: dma sink and event fifo reader
module rxts_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pace
  input wire logic slow,
  // dma stream
  input wire logic dma_valid,
  input wire logic [rxts_pkg::DATA_W-1:0] dma_data,
  input wire logic dma_sof,
  input wire logic dma_eof,
  input wire logic dma_ts_valid,
  input wire logic [rxts_pkg::TS_W-1:0] dma_ts,
  output logic dma_ready,
  // event fifo
  input wire logic evt_valid,
  input wire logic [rxts_pkg::TS_W-1:0] evt_ts,
  output logic evt_pop
);
  int sof_n;
  int ts_n;
  int evt_n;
  logic [1:0] cnt_r;
  // last first byte, last closing byte, last stamp and last event taken
  logic [rxts_pkg::DATA_W-1:0] sof_d, eof_d;
  logic [rxts_pkg::TS_W-1:0] ts_last, evt_last;
  // slow pace takes one beat in four so the port fifo backs up
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      {sof_n, ts_n, evt_n} <= '0;
      {cnt_r, dma_ready, evt_pop} <= '0;
      {sof_d, eof_d, ts_last, evt_last} <= '0;
    end
    else
    begin
      cnt_r <= cnt_r + 2'h1;
      dma_ready <= !slow || cnt_r == 2'h3;
      if (dma_valid && dma_ready && dma_sof)
      begin
        sof_n <= sof_n + 1;
        ts_n <= ts_n + int'(dma_ts_valid);
        sof_d <= dma_data;
        if (dma_ts_valid)
          ts_last <= dma_ts;
      end
      if (dma_valid && dma_ready && dma_eof)
        eof_d <= dma_data;
      evt_pop <= evt_valid && !evt_pop; // events fetched apart from payload
      if (evt_valid && evt_pop)
      begin
        evt_n <= evt_n + 1;
        evt_last <= evt_ts;
      end
    end
endmodule

/* File: dv/rxts_top_tb.sv */
`timescale 1ns/1ps
// bench for the receive timestamp path
module rxts_top_tb;
  logic core_clk = 0;
  logic reset_n = 0;
  logic host_ts_en = 0;
  logic rx_valid = 0;
  logic rx_sof = 0;
  logic rx_eof = 0;
  logic rx_preamble_ok = 1;
  logic slow = 0;
  logic [7:0] rx_data = 8'h00;
  logic [15:0] evt_etype = 16'h1234;
  logic [31:0] stamp [16];
  int tnow, nsof, n0;
  logic rx_ready, dma_valid, dma_ready, dma_sof, dma_eof, dma_ts_valid, evt_pop, evt_valid, port_stalled;
  logic [7:0] dma_data;
  logic [31:0] dma_ts, evt_ts;
  int bad_count, cmp_count, cyc, s0, t0, e0;
  rxts_top u_rxts_top (.CORE_CLK(core_clk), .RESET_N(reset_n), .HOST_TS_EN(host_ts_en), .EVT_ETYPE(evt_etype),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_SOF(rx_sof), .RX_EOF(rx_eof), .RX_PREAMBLE_OK(rx_preamble_ok),
    .RX_READY(rx_ready), .DMA_VALID(dma_valid), .DMA_READY(dma_ready), .DMA_DATA(dma_data), .DMA_SOF(dma_sof),
    .DMA_EOF(dma_eof), .DMA_TS_VALID(dma_ts_valid), .DMA_TS(dma_ts), .EVT_POP(evt_pop), .EVT_VALID(evt_valid),
    .EVT_TS(evt_ts), .PORT_STALLED(port_stalled));
  rxts_host u_rxts_host (.clk(core_clk), .rst_n(reset_n), .slow(slow), .dma_valid(dma_valid), .dma_data(dma_data),
    .dma_sof(dma_sof), .dma_eof(dma_eof), .dma_ts_valid(dma_ts_valid), .dma_ts(dma_ts), .dma_ready(dma_ready),
    .evt_valid(evt_valid), .evt_ts(evt_ts), .evt_pop(evt_pop));
  // cycles since reset release, latched for every first beat taken: the expected stamps
  always @(posedge core_clk)
    if (reset_n)
    begin
      tnow <= tnow + 1;
      if (rx_valid && rx_ready && rx_sof)
      begin
        stamp[nsof] <= 32'(tnow);
        nsof <= nsof + 1;
      end
    end
  // 25 MHz clock and a hang guard
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // beat held from a falling edge until a rising edge sees ready
  task automatic beat(input logic [7:0] d, input logic s, input logic e, input logic p);
    {rx_valid, rx_data, rx_sof, rx_eof, rx_preamble_ok} = {1'b1, d, s, e, p};
    while (rx_ready !== 1'b1)
      @(negedge core_clk);
    @(negedge core_clk);
  endtask
  // four beats, ethertype right after the first
  task automatic frame(input logic [15:0] et, input logic p);
    beat(8'hA5, 1, 0, p);
    beat(et[15:8], 0, 0, 1);
    beat(et[7:0], 0, 0, 1);
    beat(8'h5A, 0, 1, 1);
  endtask
  task automatic settle(input int s, input int e);
    rx_valid = 0;
    for (int i = 0; i < 300 && (u_rxts_host.sof_n < s || u_rxts_host.evt_n < e); i++)
      @(negedge core_clk);
  endtask
  task automatic mark();
    {s0, t0, e0} = {u_rxts_host.sof_n, u_rxts_host.ts_n, u_rxts_host.evt_n};
    n0 = nsof;
  endtask
  // matching and other ethertype with host stamps off
  task automatic t_event();
    mark();
    frame(16'h1234, 1);
    frame(16'h0800, 1);
    settle(s0 + 2, e0 + 1);
    chk(u_rxts_host.evt_n, e0 + 1);
    chk(u_rxts_host.evt_last, stamp[n0]);
    chk(u_rxts_host.sof_n, s0 + 2);
    chk(u_rxts_host.ts_n, t0);
    chk(u_rxts_host.sof_d, 8'hA5);
    chk(u_rxts_host.eof_d, 8'h5A);
    // retarget the trigger: now only the other ethertype records
    evt_etype = 16'h0800;
    frame(16'h1234, 1);
    frame(16'h0800, 1);
    settle(s0 + 4, e0 + 2);
    chk(u_rxts_host.evt_n, e0 + 2);
    chk(u_rxts_host.evt_last, stamp[n0 + 3]);
    evt_etype = 16'h1234;
  endtask
  // back-to-back packets into a stalling host, all stamped
  task automatic t_host();
    host_ts_en = 1;
    slow = 1;
    mark();
    repeat (3) frame(16'h0800, 1);
    settle(s0 + 3, e0);
    slow = 0;
    chk(u_rxts_host.ts_n, t0 + 3);
    chk(u_rxts_host.ts_last, stamp[n0 + 2]);
    chk(u_rxts_host.evt_n, e0);
  endtask
  // bad preamble locks the port until host stamps go off
  task automatic t_lock();
    mark();
    frame(16'h0800, 0);
    settle(s0, e0);
    chk(port_stalled, 1);
    chk(rx_ready, 0);
    chk(u_rxts_host.sof_n, s0);
    host_ts_en = 0;
    settle(s0 + 1, e0);
    chk(port_stalled, 0);
    chk(rx_ready, 1);
    chk(u_rxts_host.ts_n, t0);
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset, then the scenarios
  initial
  begin
    repeat (16) @(negedge core_clk);
    reset_n = 1;
    @(negedge core_clk);
    t_event();
    t_host();
    t_lock();
    tally_and_finish();
  end
endmodule
